/* include/sfi_defs.vh */
// register map and field layout of the supply fault interrupt bank
`ifndef SFI_DEFS_VH
`define SFI_DEFS_VH
`define SFI_ADDR_W 8
`define SFI_OFF_FLAGS 8'h1C
`define SFI_OFF_ENABLE 8'h20
`define SFI_OFF_CLEAR 8'h24
`define SFI_NRAIL 5
`define SFI_NFLAG 10
`define SFI_LOW_IRQ_LSB 0
`define SFI_HIGH_IRQ_LSB 5
`define SFI_LOW_STATE_LSB 16
`define SFI_HIGH_STATE_LSB 21
`define SFI_STATE_LSB 16
`define SFI_FLAGS_RESET 32'h00000000
`define SFI_ENABLE_RESET 10'h000
`endif

/* sim/sfi_asserts.sv */
// port assertions of the supply fault interrupt bank
module sfi_asserts (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_write,
  input wire logic i_read,
  input wire logic o_irq,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic [31:0] o_rdata,
  input wire logic [4:0] i_low_event,
  input wire logic [4:0] i_high_event
);
timeunit 1ns;timeprecision 100ps;
default clocking @(posedge i_clock);endclocking
default disable iff(!i_resetn);
wire rf=i_read&&i_addr==8'h1C;
a_low_flags: assert property(rf|=>&(o_rdata[4:0]|~$past(i_low_event,2)))else $error("uv flag");
a_high_flags: assert property(rf|=>&(o_rdata[9:5]|~$past(i_high_event,2)))else $error("ov flag");
a_low_state: assert property(rf|=>&(o_rdata[20:16]|~$past(i_low_event,2)))else $error("uv state");
a_high_state: assert property(rf|=>&(o_rdata[25:21]|~$past(i_high_event,2)))else $error("ov state");
a_spare_zero: assert property(o_rdata[15:10]==0&&o_rdata[31:26]==0)else $error("spare");
a_clr_read: assert property(i_read&&i_addr==8'h24|=>o_rdata==0)else $error("clr read");
a_idle_rdata: assert property(!i_read|=>o_rdata==0)else $error("idle read data");
a_mask_irq: assert property(i_write&&i_addr==8'h20&&i_wdata[9:0]==0|=>!o_irq)else $error("mask");
a_clear_irq: assert property(i_write&&i_addr==8'h24&&i_wdata[9:0]==10'h3FF&&!i_low_event&&!i_high_event
|=>!o_irq)else $error("clear");
endmodule // sfi_asserts
bind sfi_supply_fault_irq sfi_asserts u_chk(
  .i_clock(i_clock),
  .i_resetn(i_resetn),
  .i_write(i_write),
  .i_read(i_read),
  .o_irq(o_irq),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .o_rdata(o_rdata),
  .i_low_event(i_low_event),
  .i_high_event(i_high_event)
);

/* sim/sfi_supply_fault_irq_test.sv */
// self-checking bench of the supply fault interrupt bank
module sfi_supply_fault_irq_test;
timeunit 1ns;timeprecision 100ps;
logic i_clock=0,i_resetn=0,i_write=0,i_read=0,o_irq;
logic [7:0] i_addr=0;logic [31:0] i_wdata=0,o_rdata;logic [4:0] i_low_event=0,i_high_event=0;
int bad_count=0,n_compared=0;
sfi_supply_fault_irq u_dut(
  .i_clock(i_clock),
  .i_resetn(i_resetn),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .i_write(i_write),
  .i_read(i_read),
  .o_rdata(o_rdata),
  .i_low_event(i_low_event),
  .i_high_event(i_high_event),
  .o_irq(o_irq)
);
initial forever #12.5 i_clock=~i_clock;
task chk(logic [31:0] s,e);
n_compared++;
if(s!==e) begin
bad_count++;$display("mismatch %0t seen %h expected %h",$time,s,e);
end
endtask
task wr(logic [7:0] x,logic [31:0] y,logic q);
@(posedge i_clock) {i_addr,i_wdata,i_write}<={x,y,1'b1};
@(posedge i_clock) i_write<=0;
#1 chk(o_irq,q);
endtask
task rd(logic [7:0] x,logic [31:0] e);
@(posedge i_clock) {i_addr,i_read}<={x,1'b1};
@(posedge i_clock) i_read<=0;
#1 chk(o_rdata,e);
endtask
task end_of_test;
$display("compared %0d bad %0d",n_compared,bad_count);
if(bad_count==0&&n_compared>0) $display("Result: passed");
else $display("Result: failed");
$finish;
endtask
initial begin
repeat(2) @(posedge i_clock);
i_resetn<=1;
rd(8'h1C,0);
rd(8'h20,0);
@(posedge i_clock) {i_low_event,i_high_event}<=10'h2AA;
@(posedge i_clock) {i_low_event,i_high_event}<=0;
rd(8'h1C,32'h01550155);
wr(8'h1C,~0,0);
rd(8'h1C,32'h01550155);
wr(8'h20,32'h3FF,1);
rd(8'h20,32'h3FF);
wr(8'h20,0,0);
wr(8'h24,32'h03FF03FF,0);
rd(8'h1C,0);
rd(8'h24,0);
rd(8'h40,0);
@(posedge i_clock) begin
  {i_addr,i_wdata,i_write}<={8'h24,32'h03FF03FF,1'b1};
  i_low_event<=5'h01;
end
@(posedge i_clock) begin
  i_write<=0;
  i_low_event<=0;
end
rd(8'h1C,32'h00010001);
wr(8'h20,32'h3FE,0);
wr(8'h20,32'h001,1);
wr(8'h24,32'h00010000,1);
rd(8'h1C,32'h00000001);
wr(8'h24,32'h00000001,0);
rd(8'h1C,0);
wr(8'h20,32'h200,0);
@(posedge i_clock) i_high_event<=5'h10;
@(posedge i_clock) i_high_event<=0;
#1 chk(o_irq,1);
@(posedge i_clock) i_resetn<=0;
@(posedge i_clock) #1 chk(o_irq,0);
@(posedge i_clock) i_resetn<=1;
rd(8'h1C,0);
rd(8'h20,0);
end_of_test;
end
endmodule // sfi_supply_fault_irq_test

/* verilog/sfi_irq_gate.v */
// masks the interrupt flags with their enables into one level request
module sfi_irq_gate (
  input wire [9:0] i_flags,
  input wire [9:0] i_enable,
  output wire o_irq
);
  assign o_irq = |(i_flags & i_enable);
endmodule // sfi_irq_gate

/* verilog/sfi_sticky_bit.v */
// one sticky event bit: hardware set wins over a software clear
module sfi_sticky_bit (
  input wire i_clock,
  input wire i_resetn,
  input wire i_set,
  input wire i_clear,
  output reg o_bit
);
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_bit <= 1'b0;
    end else if (i_set) begin
      o_bit <= 1'b1;
    end else if (i_clear) begin
      o_bit <= 1'b0;
    end
  end
endmodule // sfi_sticky_bit

/* verilog/sfi_supply_fault_irq.v */
// supply fault interrupt flags, state bits, enable and clear registers
`include "sfi_defs.vh"
module sfi_supply_fault_irq (
  input wire i_clock,
  input wire i_resetn,
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_write,
  input wire i_read,
  output reg [31:0] o_rdata,
  input wire [4:0] i_low_event,
  input wire [4:0] i_high_event,
  output wire o_irq
);
  // storage, raw vectors and access decode
  reg [9:0] enable_r;
  reg [9:0] enable_nxt;
  wire [9:0] irq_flag;
  wire [9:0] state_bit;
  wire [9:0] event_vec;
  wire [9:0] irq_clear_vec;
  wire [9:0] state_clear_vec;
  wire clear_wr;
  wire enable_wr;
  wire flags_rd;
  wire enable_rd;
  wire sel_flags;
  wire sel_enable;
  wire sel_clear;
  wire [31:0] flags_view;
  wire [31:0] enable_view;
  reg [31:0] rdata_nxt;

  // one named wire per field of the flag register
  wire battery_low_irq_flag;
  wire main_supply_low_irq_flag;
  wire rail5_low_irq_flag;
  wire core_rail_low_irq_flag;
  wire ext_rail_low_irq_flag;
  wire battery_high_irq_flag;
  wire main_supply_high_irq_flag;
  wire rail5_high_irq_flag;
  wire core_rail_high_irq_flag;
  wire ext_rail_high_irq_flag;
  wire battery_low_state;
  wire main_supply_low_state;
  wire rail5_low_state;
  wire core_rail_low_state;
  wire ext_rail_low_state;
  wire battery_high_state;
  wire main_supply_high_state;
  wire rail5_high_state;
  wire core_rail_high_state;
  wire ext_rail_high_state;

  // five-rail groups in rail order
  wire [4:0] low_irq_field;
  wire [4:0] high_irq_field;
  wire [4:0] low_state_field;
  wire [4:0] high_state_field;

  // one named wire per enable bit
  wire battery_low_irq_enable;
  wire main_supply_low_irq_enable;
  wire rail5_low_irq_enable;
  wire core_rail_low_irq_enable;
  wire ext_rail_low_irq_enable;
  wire battery_high_irq_enable;
  wire main_supply_high_irq_enable;
  wire rail5_high_irq_enable;
  wire core_rail_high_irq_enable;
  wire ext_rail_high_irq_enable;

  // one named clear strobe per field
  wire battery_low_irq_clear;
  wire main_supply_low_irq_clear;
  wire rail5_low_irq_clear;
  wire core_rail_low_irq_clear;
  wire ext_rail_low_irq_clear;
  wire battery_high_irq_clear;
  wire main_supply_high_irq_clear;
  wire rail5_high_irq_clear;
  wire core_rail_high_irq_clear;
  wire ext_rail_high_irq_clear;
  wire battery_low_state_clear;
  wire main_supply_low_state_clear;
  wire rail5_low_state_clear;
  wire core_rail_low_state_clear;
  wire ext_rail_low_state_clear;
  wire battery_high_state_clear;
  wire main_supply_high_state_clear;
  wire rail5_high_state_clear;
  wire core_rail_high_state_clear;
  wire ext_rail_high_state_clear;

  // writes to the flag register itself have no effect
  assign sel_flags = (i_addr == `SFI_OFF_FLAGS);
  assign sel_enable = (i_addr == `SFI_OFF_ENABLE);
  assign sel_clear = (i_addr == `SFI_OFF_CLEAR);
  assign clear_wr = i_write && sel_clear;
  assign enable_wr = i_write && sel_enable;
  assign flags_rd = i_read && sel_flags;
  assign enable_rd = i_read && sel_enable;

  assign event_vec = {i_high_event, i_low_event};

  // clear bits sit at the same positions as the bits they clear
  assign battery_low_irq_clear = clear_wr && i_wdata[`SFI_LOW_IRQ_LSB];
  assign main_supply_low_irq_clear = clear_wr && i_wdata[`SFI_LOW_IRQ_LSB + 1];
  assign rail5_low_irq_clear = clear_wr && i_wdata[`SFI_LOW_IRQ_LSB + 2];
  assign core_rail_low_irq_clear = clear_wr && i_wdata[`SFI_LOW_IRQ_LSB + 3];
  assign ext_rail_low_irq_clear = clear_wr && i_wdata[`SFI_LOW_IRQ_LSB + 4];
  assign battery_high_irq_clear = clear_wr && i_wdata[`SFI_HIGH_IRQ_LSB];
  assign main_supply_high_irq_clear = clear_wr && i_wdata[`SFI_HIGH_IRQ_LSB + 1];
  assign rail5_high_irq_clear = clear_wr && i_wdata[`SFI_HIGH_IRQ_LSB + 2];
  assign core_rail_high_irq_clear = clear_wr && i_wdata[`SFI_HIGH_IRQ_LSB + 3];
  assign ext_rail_high_irq_clear = clear_wr && i_wdata[`SFI_HIGH_IRQ_LSB + 4];
  assign battery_low_state_clear = clear_wr && i_wdata[`SFI_LOW_STATE_LSB];
  assign main_supply_low_state_clear = clear_wr && i_wdata[`SFI_LOW_STATE_LSB + 1];
  assign rail5_low_state_clear = clear_wr && i_wdata[`SFI_LOW_STATE_LSB + 2];
  assign core_rail_low_state_clear = clear_wr && i_wdata[`SFI_LOW_STATE_LSB + 3];
  assign ext_rail_low_state_clear = clear_wr && i_wdata[`SFI_LOW_STATE_LSB + 4];
  assign battery_high_state_clear = clear_wr && i_wdata[`SFI_HIGH_STATE_LSB];
  assign main_supply_high_state_clear = clear_wr && i_wdata[`SFI_HIGH_STATE_LSB + 1];
  assign rail5_high_state_clear = clear_wr && i_wdata[`SFI_HIGH_STATE_LSB + 2];
  assign core_rail_high_state_clear = clear_wr && i_wdata[`SFI_HIGH_STATE_LSB + 3];
  assign ext_rail_high_state_clear = clear_wr && i_wdata[`SFI_HIGH_STATE_LSB + 4];

  assign irq_clear_vec = {
    ext_rail_high_irq_clear,
    core_rail_high_irq_clear,
    rail5_high_irq_clear,
    main_supply_high_irq_clear,
    battery_high_irq_clear,
    ext_rail_low_irq_clear,
    core_rail_low_irq_clear,
    rail5_low_irq_clear,
    main_supply_low_irq_clear,
    battery_low_irq_clear
  };
  assign state_clear_vec = {
    ext_rail_high_state_clear,
    core_rail_high_state_clear,
    rail5_high_state_clear,
    main_supply_high_state_clear,
    battery_high_state_clear,
    ext_rail_low_state_clear,
    core_rail_low_state_clear,
    rail5_low_state_clear,
    main_supply_low_state_clear,
    battery_low_state_clear
  };

  genvar g;
  generate
    for (g = 0; g < `SFI_NFLAG; g = g + 1) begin : g_flag
      sfi_sticky_bit u_irq (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_set(event_vec[g]),
        .i_clear(irq_clear_vec[g]),
        .o_bit(irq_flag[g])
      );
      sfi_sticky_bit u_state (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_set(event_vec[g]),
        .i_clear(state_clear_vec[g]),
        .o_bit(state_bit[g])
      );
    end
  endgenerate

  // field view of the sticky bits, rail order battery, main, 5V, 1.5V, external
  assign battery_low_irq_flag = irq_flag[0];
  assign main_supply_low_irq_flag = irq_flag[1];
  assign rail5_low_irq_flag = irq_flag[2];
  assign core_rail_low_irq_flag = irq_flag[3];
  assign ext_rail_low_irq_flag = irq_flag[4];
  assign battery_high_irq_flag = irq_flag[5];
  assign main_supply_high_irq_flag = irq_flag[6];
  assign rail5_high_irq_flag = irq_flag[7];
  assign core_rail_high_irq_flag = irq_flag[8];
  assign ext_rail_high_irq_flag = irq_flag[9];
  assign battery_low_state = state_bit[0];
  assign main_supply_low_state = state_bit[1];
  assign rail5_low_state = state_bit[2];
  assign core_rail_low_state = state_bit[3];
  assign ext_rail_low_state = state_bit[4];
  assign battery_high_state = state_bit[5];
  assign main_supply_high_state = state_bit[6];
  assign rail5_high_state = state_bit[7];
  assign core_rail_high_state = state_bit[8];
  assign ext_rail_high_state = state_bit[9];

  assign low_irq_field = {
    ext_rail_low_irq_flag,
    core_rail_low_irq_flag,
    rail5_low_irq_flag,
    main_supply_low_irq_flag,
    battery_low_irq_flag
  };
  assign high_irq_field = {
    ext_rail_high_irq_flag,
    core_rail_high_irq_flag,
    rail5_high_irq_flag,
    main_supply_high_irq_flag,
    battery_high_irq_flag
  };
  assign low_state_field = {
    ext_rail_low_state,
    core_rail_low_state,
    rail5_low_state,
    main_supply_low_state,
    battery_low_state
  };
  assign high_state_field = {
    ext_rail_high_state,
    core_rail_high_state,
    rail5_high_state,
    main_supply_high_state,
    battery_high_state
  };

  // reserved ranges are constant zero
  assign flags_view = {
    6'h00,
    high_state_field,
    low_state_field,
    6'h00,
    high_irq_field,
    low_irq_field
  };

  assign battery_low_irq_enable = enable_r[0];
  assign main_supply_low_irq_enable = enable_r[1];
  assign rail5_low_irq_enable = enable_r[2];
  assign core_rail_low_irq_enable = enable_r[3];
  assign ext_rail_low_irq_enable = enable_r[4];
  assign battery_high_irq_enable = enable_r[5];
  assign main_supply_high_irq_enable = enable_r[6];
  assign rail5_high_irq_enable = enable_r[7];
  assign core_rail_high_irq_enable = enable_r[8];
  assign ext_rail_high_irq_enable = enable_r[9];

  assign enable_view = {
    22'h000000,
    ext_rail_high_irq_enable,
    core_rail_high_irq_enable,
    rail5_high_irq_enable,
    main_supply_high_irq_enable,
    battery_high_irq_enable,
    ext_rail_low_irq_enable,
    core_rail_low_irq_enable,
    rail5_low_irq_enable,
    main_supply_low_irq_enable,
    battery_low_irq_enable
  };

  always @* begin
    enable_nxt = enable_r;
    if (enable_wr) begin
      enable_nxt = i_wdata[9:0];
    end
  end

  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      enable_r <= `SFI_ENABLE_RESET;
    end else begin
      enable_r <= enable_nxt;
    end
  end

  // clear register and unmapped offsets read zero
  always @* begin
    rdata_nxt = 32'h00000000;
    if (flags_rd) begin
      rdata_nxt = flags_view;
    end else if (enable_rd) begin
      rdata_nxt = enable_view;
    end
  end

  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= `SFI_FLAGS_RESET;
    end else begin
      o_rdata <= rdata_nxt;
    end
  end

  sfi_irq_gate u_gate (
    .i_flags(irq_flag),
    .i_enable(enable_r),
    .o_irq(o_irq)
  );
endmodule // sfi_supply_fault_irq
